// ### testbench/cprm_mac_model.sv
// behavioural mac driving the mii transmit side
`default_nettype none
module cprm_mac_model (
	input  wire logic       ref_clk,   // system clock
	input  wire logic       mii_crs,   // throttle from the phy
	output logic            mii_tx_en, // transmit enable
	output logic      [3:0] mii_txd    // transmit nibble
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] oct_q[$]; // octets of the next frame
	int         waits;    // deferral cycles spent
	logic       defer_to; // deferral bound ran out
	initial begin
		mii_tx_en = 1'b0;
		mii_txd   = 4'h0;
		defer_to  = 1'b0;
	end
	// one frame: wait for carrier to drop, then preamble, sfd and octets low nibble first
	task automatic send_frame();
		logic [7:0] b;
		waits = 0;
		@(negedge ref_clk);
		// bounded so a stuck throttle cannot hang the run
		while (mii_crs !== 1'b0 && waits < 20000) begin
			@(negedge ref_clk);
			waits++;
		end
		defer_to  = (waits >= 20000);
		mii_tx_en = 1'b1;
		for (int i = 0; i < 16; i++) begin
			mii_txd = (i == 15) ? 4'hd : 4'h5;
			@(negedge ref_clk);
		end
		while (oct_q.size() > 0) begin
			b       = oct_q.pop_front();
			mii_txd = b[3:0];
			@(negedge ref_clk);
			mii_txd = b[7:4];
			@(negedge ref_clk);
		end
		mii_tx_en = 1'b0;
		// idle line shows a changed value, never the last nibble
		mii_txd   = ~mii_txd;
	endtask : send_frame
endmodule : cprm_mac_model
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the rate-match block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_b, clk_en, mii_tx_en, mii_rx_dv, mii_crs, mii_col; // mii side
	logic [3:0] mii_txd, mii_rxd;                           // mii nibbles
	logic defer_mode, bond_present, bond_wr, hold_acc, en_rand; // modes, write, stall, gating
	logic [4:0] port_addr_strap, port_addr, line_tx_lane;     // addresses, lane
	logic [31:0] phys_line_mask, other_bond_mask, bond_wr_data; // mask inputs
	logic [31:0] bondable_line_mask, active_line_bond_mask, d; // mask outputs, scratch
	logic line_tx_accept, line_tx_valid, line_tx_eof;         // line transmit
	logic line_rx_push, line_rx_eof, line_rx_full;            // line receive
	logic [7:0] line_tx_data, line_rx_data;                   // line octets
	logic [13:0] txq[$];  // expected lane, eof, octet
	logic [3:0]  rxq[$];  // expected receive nibbles
	logic [13:0] e;       // popped entry
	int num_errors, check_count, n;
	cprm_rate_match u_cprm_rate_match (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.mii_tx_en(mii_tx_en), .mii_txd(mii_txd), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd),
		.mii_crs(mii_crs), .mii_col(mii_col), .defer_mode(defer_mode),
		.bond_present(bond_present), .port_addr_strap(port_addr_strap),
		.port_addr(port_addr), .phys_line_mask(phys_line_mask),
		.other_bond_mask(other_bond_mask), .bond_wr(bond_wr), .bond_wr_data(bond_wr_data),
		.bondable_line_mask(bondable_line_mask),
		.active_line_bond_mask(active_line_bond_mask), .line_tx_accept(line_tx_accept),
		.line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
		.line_tx_eof(line_tx_eof), .line_tx_lane(line_tx_lane),
		.line_rx_push(line_rx_push), .line_rx_data(line_rx_data),
		.line_rx_eof(line_rx_eof), .line_rx_full(line_rx_full));
	cprm_mac_model u_cprm_mac_model (.ref_clk(ref_clk), .mii_crs(mii_crs),
		.mii_tx_en(mii_tx_en), .mii_txd(mii_txd));
	// 100 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// line side pulls at a random pace, or stalls on request
	always @(negedge ref_clk) line_tx_accept <= hold_acc ? 1'b0 : 1'($urandom % 2);
	// clock enable gaps on request, so frozen cycles are exercised on the mii side
	always @(negedge ref_clk) clk_en <= en_rand ? 1'(($urandom % 4) != 0) : 1'b1;
	// counted compare, reports at once
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// queue a frame at the mac and note the octets the line side must see
	task automatic mac_tx(input int len, input logic [4:0] lane);
		logic [7:0] b;
		for (int i = 0; i < len; i++) begin
			b = 8'($urandom);
			u_cprm_mac_model.oct_q.push_back(b);
			txq.push_back({lane, (i == len - 1), b});
		end
		u_cprm_mac_model.send_frame();
		check("mac_defer", 32'h0, 32'(u_cprm_mac_model.defer_to));
		if (u_cprm_mac_model.defer_to) print_verdict();
	endtask : mac_tx
	// push a frame from the line side; mac must see preamble, sfd, then nibbles
	task automatic push_rx(input int len);
		logic [7:0] b;
		for (int i = 0; i < 15; i++) rxq.push_back(4'h5);
		rxq.push_back(4'hd);
		for (int i = 0; i < len; i++) begin
			b = 8'($urandom);
			rxq.push_back(b[3:0]);
			rxq.push_back(b[7:4]);
			line_rx_push = 1'b1;
			line_rx_data = b;
			line_rx_eof  = (i == len - 1);
			@(negedge ref_clk);
		end
		line_rx_push = 1'b0;
		line_rx_data = ~line_rx_data;
	endtask : push_rx
	// wait until every noted result has shown up
	task automatic drain();
		int k;
		k = 0;
		while ((txq.size() + rxq.size()) > 0 && k < 40000) begin
			@(negedge ref_clk);
			k++;
		end
		if (k >= 40000) begin
			num_errors++;
			$display("Error drain expected 0 seen %0d", txq.size() + rxq.size());
			print_verdict();
		end
	endtask : drain
	// watcher: each accepted octet and each delivered nibble takes the oldest note
	always @(posedge ref_clk) begin
		if (rst_b && clk_en && line_tx_valid && line_tx_accept) begin
			e = (txq.size() > 0) ? txq.pop_front() : 14'h3fff;
			check("line_tx_octet", 32'(e[8:0]), {line_tx_eof, line_tx_data});
			if (e[8]) check("line_tx_lane", 32'(e[13:9]), 32'(line_tx_lane));
		end
		if (rst_b && clk_en && mii_rx_dv) check("mii_rxd", (rxq.size() > 0) ?
			32'(rxq.pop_front()) : 32'h10, 32'(mii_rxd));
	end
	initial begin
		{rst_b, en_rand, bond_wr, defer_mode, bond_present, line_rx_push} = 6'h00;
		{line_rx_eof, line_rx_data, bond_wr_data} = 41'h0;
		hold_acc        = 1'b1;
		num_errors      = 0;
		check_count     = 0;
		void'($urandom(62573));
		port_addr_strap = 5'($urandom);
		phys_line_mask  = 32'hffff_ffff;
		other_bond_mask = 32'h0000_0001;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk) rst_b = 1'b1;
		repeat (3) @(negedge ref_clk);
		check("port_addr", 32'(port_addr_strap), 32'(port_addr));
		check("active_mask_rst", 32'h0, active_line_bond_mask);
		check("mii_col", 32'h0, 32'(mii_col));
		check("mii_crs_idle", 32'h0, 32'(mii_crs));
		// random mask writes, then a known one for lane rotation
		for (int i = 0; i < 5; i++) begin
			phys_line_mask  = (i == 4) ? 32'hffff_ffff : $urandom;
			other_bond_mask = (i == 4) ? 32'h0000_0001 : $urandom;
			d               = (i == 4) ? 32'h0000_0209 : $urandom;
			bond_wr_data    = d;
			bond_wr         = 1'b1;
			@(negedge ref_clk);
			check("bondable_mask", phys_line_mask & ~other_bond_mask, bondable_line_mask);
			check("active_mask", d & phys_line_mask & ~other_bond_mask,
				active_line_bond_mask);
		end
		// write strobe held across the loop, dropped once after the last write
		bond_wr = 1'b0;
		// lanes 3 and 9 are bonded: frames rotate 3, 9, 3
		bond_present = 1'b1;
		hold_acc     = 1'b0;
		mac_tx(20, 5'h03);
		mac_tx(1, 5'h09);
		mac_tx(7, 5'h03);
		drain();
		bond_present = 1'b0;
		mac_tx(6, 5'h00);
		drain();
		// stalled line: a long frame leaves too little room, carrier holds
		hold_acc = 1'b1;
		mac_tx(2600, 5'h00);
		repeat (4) @(negedge ref_clk);
		check("mii_crs_full", 32'h1, 32'(mii_crs));
		hold_acc = 1'b0;
		drain();
		repeat (4) @(negedge ref_clk);
		check("mii_crs_room", 32'h0, 32'(mii_crs));
		push_rx(10);
		// delivery with enable gaps: the watcher skips frozen edges
		en_rand = 1'b1;
		drain();
		en_rand = 1'b0;
		@(negedge ref_clk);
		// deferral: carrier covers delivery and the mac frame waits behind it
		defer_mode = 1'b1;
		push_rx(30);
		n = 0;
		while (mii_rx_dv !== 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 100) begin
			num_errors++;
			$display("Error rx_dv_wait expected 1 seen %0d", n);
			print_verdict();
		end
		repeat (3) @(negedge ref_clk);
		check("mii_crs_defer", 32'h1, 32'(mii_crs));
		mac_tx(4, 5'h00);
		check("rx_first", 32'h0, 32'(rxq.size()));
		drain();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire

// ### verilog/cprm_consts.svh
// constants for the copper rate-match and line bonding block
`ifndef CPRM_CONSTS_SVH
`define CPRM_CONSTS_SVH
`define CPRM_BUF_AW     12
`define CPRM_BUF_DEPTH  4096
`define CPRM_CNT_W      13
`define CPRM_MAX_FRAME  13'h5f2
`define CPRM_PRE_LAST   4'hf
`define CPRM_GAP_LAST   5'h17
`define CPRM_PRE_NIB    4'h5
`define CPRM_SFD_HI     4'hd
`define CPRM_LINES      32
`define CPRM_MASK_RST   32'h0000_0000
`define CPRM_EOF_BIT    8
`endif

// ### verilog/cprm_frame_buf.sv
// octet frame buffer with end-of-frame tag and frame count
`include "cprm_consts.svh"
`default_nettype none
module cprm_frame_buf (
	input  wire logic                   ref_clk,  // system clock
	input  wire logic                   rst_b,    // async reset, low
	input  wire logic                   clk_en,   // freezes state when low
	input  wire logic                   wr_en,    // push one octet
	input  wire logic [8:0]             wr_data,  // eof tag + octet
	input  wire logic                   rd_en,    // pop one octet
	output logic      [8:0]             rd_data,  // head entry
	output logic                        empty,    // no octet stored
	output logic                        full,     // no room left
	output logic      [`CPRM_CNT_W-1:0] free_cnt, // free octets
	output logic      [`CPRM_CNT_W-1:0] frames    // whole frames held
);
	logic [8:0]             mem [0:`CPRM_BUF_DEPTH-1]; // storage
	logic [`CPRM_BUF_AW-1:0] wp_r;                      // write pointer
	logic [`CPRM_BUF_AW-1:0] rp_r;                      // read pointer
	logic [`CPRM_CNT_W-1:0]  used_r;                    // octets held
	logic [`CPRM_CNT_W-1:0]  frm_r;                     // frames held
	logic                    do_wr;                     // qualified write
	logic                    do_rd;                     // qualified read

	// writes into a full buffer are dropped rather than corrupt the head
	assign do_wr    = clk_en && wr_en && !full;
	assign do_rd    = clk_en && rd_en && !empty;
	assign empty    = (used_r == '0);
	assign full     = (used_r == `CPRM_CNT_W'(`CPRM_BUF_DEPTH));
	assign free_cnt = `CPRM_CNT_W'(`CPRM_BUF_DEPTH) - used_r;
	assign frames   = frm_r;
	assign rd_data  = mem[rp_r];

	// storage array, no reset needed
	always_ff @(posedge ref_clk) begin
		if (do_wr) begin
			mem[wp_r] <= wr_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r   <= '0;
			rp_r   <= '0;
			used_r <= '0;
		end else begin
			if (do_wr) begin
				wp_r <= wp_r + 1'b1;
			end
			if (do_rd) begin
				rp_r <= rp_r + 1'b1;
			end
			used_r <= used_r + `CPRM_CNT_W'(do_wr) - `CPRM_CNT_W'(do_rd);
		end
	end

	// frame count follows tagged last octets in and out
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			frm_r <= '0;
		end else begin
			frm_r <= frm_r + `CPRM_CNT_W'(do_wr && wr_data[`CPRM_EOF_BIT])
			       - `CPRM_CNT_W'(do_rd && rd_data[`CPRM_EOF_BIT]);
		end
	end
endmodule : cprm_frame_buf
`default_nettype wire

// ### verilog/cprm_pkg.sv
// types shared by the rate-match block
`default_nettype none
package cprm_pkg;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_PRE  = 2'b01,
		RX_DAT  = 2'b11,
		RX_GAP  = 2'b10
	} cprm_rx_st_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_PRE  = 2'b01,
		TX_DAT  = 2'b11
	} cprm_tx_st_t;
endpackage : cprm_pkg
`default_nettype wire

// ### verilog/cprm_rate_match.sv
// mac-side rate matching with line bonding masks
// Function
// - hold crs until room for maximum frame
// - drive col low always
// - accept mii transmit data, buffer internally
// - strip preamble and sfd on transmit
// - store whole frame, add preamble, deliver
// - deferral mode asserts crs during receive
// - receive frames take precedence in deferral
// - crs may throttle in full duplex
// - no mii management interface
// - optional bonding joins lines into link
// - bondable mask from connectivity and others
// - active mask selects bonded lines
// - port address is one of 32
// - line side paced separately from mii
// - one nibble per clock each direction
// - line side pulls transmit on accept
// - line side pushes receive data
`include "cprm_consts.svh"
`default_nettype none
module cprm_rate_match (
	input  wire logic        ref_clk,          // system clock, 100 MHz
	input  wire logic        rst_b,            // async reset, low
	input  wire logic        clk_en,           // nibble enable, freezes all
	input  wire logic        mii_tx_en,        // mac transmit enable
	input  wire logic [3:0]  mii_txd,          // mac transmit nibble
	output logic             mii_rx_dv,        // receive data valid
	output logic      [3:0]  mii_rxd,          // receive nibble
	output logic             mii_crs,          // carrier sense / throttle
	output logic             mii_col,          // collision, held low
	input  wire logic        defer_mode,       // half-duplex deferral mode
	input  wire logic        bond_present,     // bonding function fitted
	input  wire logic [4:0]  port_addr_strap,  // management port address
	output logic      [4:0]  port_addr,        // captured port address
	input  wire logic [31:0] phys_line_mask,   // physically reachable lines
	input  wire logic [31:0] other_bond_mask,  // lines bonded elsewhere
	input  wire logic        bond_wr,          // write active mask
	input  wire logic [31:0] bond_wr_data,     // new active mask
	output logic      [31:0] bondable_line_mask,   // lines free to bond
	output logic      [31:0] active_line_bond_mask, // lines bonded here
	input  wire logic        line_tx_accept,   // line side takes octet
	output logic             line_tx_valid,    // octet on offer
	output logic      [7:0]  line_tx_data,     // transmit octet
	output logic             line_tx_eof,      // last octet of frame
	output logic      [4:0]  line_tx_lane,     // line carrying this frame
	input  wire logic        line_rx_push,     // line side pushes octet
	input  wire logic [7:0]  line_rx_data,     // receive octet
	input  wire logic        line_rx_eof,      // last octet of frame
	output logic             line_rx_full      // receive buffer full
);
	cprm_pkg::cprm_tx_st_t  tx_st_r;           // transmit framing state
	cprm_pkg::cprm_rx_st_t  rx_st_r;           // receive delivery state
	logic [3:0]             tx_lo_r;           // held low nibble
	logic                   tx_hi_r;           // next nibble is high half
	logic [7:0]             tx_hold_r;         // octet awaiting eof knowledge
	logic                   tx_hold_v_r;       // hold register full
	logic                   tx_wr;             // tx buffer write
	logic [8:0]             tx_wdata;          // tx buffer write word
	logic                   tx_rd;             // tx buffer pop
	logic [8:0]             tx_head;           // tx buffer head
	logic                   tx_empty;          // tx buffer empty
	logic [`CPRM_CNT_W-1:0] tx_free;           // tx free octets
	logic                   tx_first_r;        // next pop starts a frame
	logic                   rx_rd;             // rx buffer pop
	logic [8:0]             rx_head;           // rx buffer head
	logic [`CPRM_CNT_W-1:0] rx_frames;         // whole rx frames held
	logic [4:0]             rx_cnt_r;          // preamble / gap counter
	logic                   rx_hi_r;           // sending high nibble
	logic                   rx_go;             // start delivering a frame
	logic                   strap_done_r;      // address already captured

	// mii collision never asserts, so throttling never aborts a frame
	assign mii_col = 1'b0;
	// no mdc/mdio pins: management reaches this block by plain ports

	// next bonded line after cur, wrapping; cur kept if mask is empty
	function automatic logic [4:0] next_lane(input logic [31:0] m,
	                                         input logic [4:0] cur);
		logic [4:0] n;
		logic [4:0] pick;
		logic       hit;
		pick = cur;
		hit  = 1'b0;
		for (int i = 1; i <= `CPRM_LINES; i++) begin
			n = 5'(cur + 5'(i));
			if (!hit && m[n]) begin
				pick = n;
				hit  = 1'b1;
			end
		end
		return pick;
	endfunction : next_lane

	// capture port address strap on the first enabled edge after reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_addr    <= 5'h00;
			strap_done_r <= 1'b0;
		end else if (clk_en && !strap_done_r) begin
			port_addr    <= port_addr_strap;
			strap_done_r <= 1'b1;
		end
	end

	// lines bonded into another instance drop out of this mask
	assign bondable_line_mask = phys_line_mask & ~other_bond_mask;

	// active mask: cleared at reset, only bondable lines accepted
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			active_line_bond_mask <= `CPRM_MASK_RST;
		end else if (clk_en && bond_wr) begin
			// masking here backs up software exclusivity
			active_line_bond_mask <= bond_wr_data & bondable_line_mask;
		end
	end

	// transmit framing: drop preamble until sfd high nibble seen
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_r <= cprm_pkg::TX_IDLE;
		end else if (clk_en) begin
			unique case (tx_st_r)
				cprm_pkg::TX_IDLE: begin
					if (mii_tx_en) begin
						tx_st_r <= cprm_pkg::TX_PRE;
					end
				end
				cprm_pkg::TX_PRE: begin
					if (!mii_tx_en) begin
						tx_st_r <= cprm_pkg::TX_IDLE;
					end else if (mii_txd == `CPRM_SFD_HI) begin
						tx_st_r <= cprm_pkg::TX_DAT;
					end
				end
				cprm_pkg::TX_DAT: begin
					if (!mii_tx_en) begin
						tx_st_r <= cprm_pkg::TX_IDLE;
					end
				end
				default: tx_st_r <= cprm_pkg::TX_IDLE;
			endcase
		end
	end

	// nibble pairing, low nibble first, one nibble each enabled clock
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_lo_r     <= 4'h0;
			tx_hi_r     <= 1'b0;
			tx_hold_r   <= 8'h00;
			tx_hold_v_r <= 1'b0;
		end else if (clk_en) begin
			if (tx_st_r == cprm_pkg::TX_DAT && mii_tx_en) begin
				tx_hi_r <= !tx_hi_r;
				if (!tx_hi_r) begin
					tx_lo_r <= mii_txd;
				end else begin
					tx_hold_r   <= {mii_txd, tx_lo_r};
					tx_hold_v_r <= 1'b1;
				end
			end else begin
				// a trailing odd nibble is discarded with the frame end
				tx_hi_r     <= 1'b0;
				tx_hold_v_r <= 1'b0;
			end
		end
	end

	// one octet is held back so the last can carry the eof tag
	assign tx_wr = (tx_st_r == cprm_pkg::TX_DAT) && tx_hold_v_r
	             && (!mii_tx_en || (tx_hi_r && mii_tx_en));
	assign tx_wdata = {!mii_tx_en, tx_hold_r};

	cprm_frame_buf u_tx_buf (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.wr_en    (tx_wr),
		.wr_data  (tx_wdata),
		.rd_en    (tx_rd),
		.rd_data  (tx_head),
		.empty    (tx_empty),
		.full     (),
		.free_cnt (tx_free),
		.frames   ()
	);

	// output stage refills when empty or when the line side pulls
	assign tx_rd = !tx_empty && (!line_tx_valid || line_tx_accept);

	// line transmit octet register and per-frame lane choice
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			line_tx_valid <= 1'b0;
			line_tx_data  <= 8'h00;
			line_tx_eof   <= 1'b0;
			line_tx_lane  <= 5'h1f;
			tx_first_r    <= 1'b1;
		end else if (clk_en) begin
			if (tx_rd) begin
				line_tx_valid <= 1'b1;
				line_tx_data  <= tx_head[7:0];
				line_tx_eof   <= tx_head[`CPRM_EOF_BIT];
				tx_first_r    <= tx_head[`CPRM_EOF_BIT];
				if (tx_first_r && bond_present) begin
					// frames spread over bonded lines in turn
					line_tx_lane <= next_lane(active_line_bond_mask, line_tx_lane);
				end else if (!bond_present) begin
					line_tx_lane <= 5'h00;
				end
			end else if (line_tx_accept) begin
				line_tx_valid <= 1'b0;
			end
		end
	end

	// receive buffer filled only by line side push strobes
	cprm_frame_buf u_rx_buf (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.wr_en    (line_rx_push),
		.wr_data  ({line_rx_eof, line_rx_data}),
		.rd_en    (rx_rd),
		.rd_data  (rx_head),
		.empty    (),
		.full     (line_rx_full),
		.free_cnt (),
		.frames   (rx_frames)
	);

	// a frame goes up only once complete; deferral waits for mac idle
	assign rx_go = (rx_frames != '0)
	             && (!defer_mode || (!mii_tx_en && tx_st_r == cprm_pkg::TX_IDLE));
	assign rx_rd = clk_en && (rx_st_r == cprm_pkg::RX_DAT) && rx_hi_r;

	// receive delivery: preamble, sfd, data nibbles, then gap
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_r  <= cprm_pkg::RX_IDLE;
			rx_cnt_r <= 5'h00;
			rx_hi_r  <= 1'b0;
		end else if (clk_en) begin
			unique case (rx_st_r)
				cprm_pkg::RX_IDLE: begin
					rx_cnt_r <= 5'h00;
					if (rx_go) begin
						rx_st_r <= cprm_pkg::RX_PRE;
					end
				end
				cprm_pkg::RX_PRE: begin
					rx_cnt_r <= rx_cnt_r + 5'h01;
					rx_hi_r  <= 1'b0;
					if (rx_cnt_r[3:0] == `CPRM_PRE_LAST) begin
						rx_st_r <= cprm_pkg::RX_DAT;
					end
				end
				cprm_pkg::RX_DAT: begin
					rx_hi_r  <= !rx_hi_r;
					rx_cnt_r <= 5'h00;
					if (rx_hi_r && rx_head[`CPRM_EOF_BIT]) begin
						rx_st_r <= cprm_pkg::RX_GAP;
					end
				end
				cprm_pkg::RX_GAP: begin
					rx_cnt_r <= rx_cnt_r + 5'h01;
					if (rx_cnt_r == `CPRM_GAP_LAST) begin
						rx_st_r <= cprm_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	// mii receive pins registered from the delivery state
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mii_rx_dv <= 1'b0;
			mii_rxd   <= 4'h0;
		end else if (clk_en) begin
			unique case (rx_st_r)
				cprm_pkg::RX_PRE: begin
					mii_rx_dv <= 1'b1;
					mii_rxd   <= (rx_cnt_r[3:0] == `CPRM_PRE_LAST) ? `CPRM_SFD_HI
					                                               : `CPRM_PRE_NIB;
				end
				cprm_pkg::RX_DAT: begin
					mii_rx_dv <= 1'b1;
					mii_rxd   <= rx_hi_r ? rx_head[7:4] : rx_head[3:0];
				end
				default: begin
					mii_rx_dv <= 1'b0;
					mii_rxd   <= 4'h0;
				end
			endcase
		end
	end

	// crs: tx room throttle in any duplex, plus receive hold-off in defer
	// mode; asserting as soon as a frame waits lets receive win the mac
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mii_crs <= 1'b0;
		end else if (clk_en) begin
			mii_crs <= (tx_free < `CPRM_MAX_FRAME)
			        || (defer_mode && (rx_st_r != cprm_pkg::RX_IDLE
			                           || rx_frames != '0));
		end
	end
	// the mac is trusted to hold off new frames while crs is high
	// line side pacing is by accept and push strobes, taken only on clk_en cycles

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_pre_run;
		mii_rx_dv && mii_rxd == `CPRM_PRE_NIB [*8];
	endsequence

	chk_col_held_low: assert property (mii_col == 1'b0)
		else $error("col asserted");
	chk_crs_tx_room: assert property (clk_en && tx_free < `CPRM_MAX_FRAME
		|=> mii_crs)
		else $error("crs low without room for max frame");
	chk_rx_preamble_run: assert property (clk_en && $rose(mii_rx_dv)
		|-> s_pre_run)
		else $error("preamble not sent");
	chk_rx_dat_steady: assert property (clk_en && rx_st_r == cprm_pkg::RX_DAT
		|=> mii_rx_dv)
		else $error("rx_dv dropped inside frame");
	chk_defer_crs_hold: assert property (clk_en && defer_mode && mii_rx_dv
		|-> mii_crs)
		else $error("crs low while delivering in defer mode");
	chk_defer_rx_first: assert property (clk_en && defer_mode
		&& rx_frames != '0 |=> mii_crs)
		else $error("receive frame waiting without crs");
	chk_bond_mask_write: assert property (clk_en && bond_wr
		|=> active_line_bond_mask == ($past(bond_wr_data) & $past(bondable_line_mask)))
		else $error("active mask write wrong");
	chk_bond_within_avail: assert property (clk_en && bond_wr
		|=> (active_line_bond_mask & ~$past(phys_line_mask)) == 32'h0000_0000)
		else $error("bonded line not physically reachable");
	chk_tx_hold_data: assert property (clk_en && line_tx_valid && !line_tx_accept
		|=> line_tx_valid && $stable(line_tx_data))
		else $error("tx octet changed without accept");
	// the first two data-phase samples must write nothing: a preamble or sfd
	// nibble left in the hold register would show up here as an early write
	chk_tx_no_preamble: assert property (clk_en && $rose(tx_st_r == cprm_pkg::TX_DAT)
		|-> !tx_wr [*2])
		else $error("octet written before first data octet formed");
endmodule : cprm_rate_match
`default_nettype wire
